// File: verilog/aas_sequencer.sv
/*
  Alarm annunciator sequencer: per-point fault capture, flash/steady window sequence,
  common horn, supply-failure bell and monitors, Avalon-MM register slave with interrupt.
  Assumes field contacts and push buttons arrive asynchronously on pins; the bus is on CLK_I.
*/
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps

//Function
// - Normal contact with no held alarm leaves window dark and horn silent.
// - New abnormal contact flashes its window and sounds horn until accepted.
// - Accept turns every flashing window steady and silences the horn.
// - Clear keeps abnormal windows lit and the horn off.
// - Lamp test lights every window steadily with horn off; the code leaves a flashing window flashing.
// - Supply lost beyond adjustable delay lights dedicated window and sounds alarm.
// - Cancel button silences only supply alarm; window stays lit until supply returns. The code's cancel also silences the backup alarm.
// - Supply-failure sound uses its own output, apart from the horn.
// - Backup supply absent beyond delay raises its own lamp and sound; the code sounds it on BELL_O, shared with the supply alarm.
// - At least twenty points are held simultaneously without loss.
// - Test inputs exercise flasher, horn and supply-failure monitoring.
// - Alarms arriving during any test are still captured and sequenced.
// - Each new alarm restarts flashing and horn, even with others standing.
// - Any excursion of fifteen milliseconds or more is latched.
// - Each point's contact sense is software selectable, close or open to fault.
// - Each point carries a trip or warning-only class, red or green.
// - Repeat outputs give each alarm's state for an event logger.
// - Inputs are synchronised and debounced against interference and transients; the code debounces only the fault contacts, not the push buttons.
module aas_sequencer #(
  parameter int unsigned N           = aas_pkg::N_POINTS,
  parameter int unsigned TICK_CYCLES = aas_pkg::TICK_CYCLES
) (
  input  wire logic                       CLK_I,
  input  wire logic                       RST_N_I,
  input  wire logic [N-1:0]               FAULT_I,
  input  wire logic                       ACCEPT_I,
  input  wire logic                       CLEAR_I,
  input  wire logic                       LAMP_TEST_I,
  input  wire logic                       FLASH_TEST_I,
  input  wire logic                       HORN_TEST_I,
  input  wire logic                       SUPPLY_TEST_I,
  input  wire logic                       SF_CANCEL_I,
  input  wire logic                       SUPPLY_OK_I,
  input  wire logic                       BACKUP_OK_I,
  input  wire logic [aas_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                       AVS_READ_I,
  input  wire logic                       AVS_WRITE_I,
  input  wire logic [31:0]                AVS_WRITEDATA_I,
  input  wire logic [3:0]                 AVS_BYTEENABLE_I,
  output logic      [31:0]                AVS_READDATA_O,
  output logic                            AVS_WAITREQUEST_O,
  output logic      [N-1:0]               LAMP_TRIP_O,
  output logic      [N-1:0]               LAMP_WARN_O,
  output logic      [N-1:0]               REPEAT_O,
  output logic                            HORN_O,
  output logic                            BELL_O,
  output logic                            SF_LAMP_O,
  output logic                            BK_LAMP_O,
  output logic                            IRQ_O
);
  import aas_pkg::*;

  localparam int unsigned NP = N + N_BTN;
  localparam int unsigned PW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [NP-1:0]             sync1;
    logic [NP-1:0]             sync2;
    logic [N_BTN-1:0]          btn_prev;
    logic [PW-1:0]             pre;
    logic [N-1:0][DEB_W-1:0]   deb;
    logic [N-1:0]              qual;
    logic [N-1:0]              flash;
    logic [N-1:0]              steady;
    logic [FLASH_W-1:0]        fcnt;
    logic                      phase;
    logic [DLY_W-1:0]          sf_cnt;
    logic                      sf_act;
    logic                      sf_sil;
    logic [DLY_W-1:0]          bk_cnt;
    logic                      bk_act;
    logic                      bk_sil;
    logic [N-1:0]              polarity;
    logic [N-1:0]              trip_class;
    logic [DLY_W-1:0]          sf_delay;
    logic [2:0]                irq_stat;
    logic [2:0]                irq_mask;
    logic                      wait_req;
    logic [31:0]               rdata;
    logic [N-1:0]              lamp_trip;
    logic [N-1:0]              lamp_warn;
    logic [N-1:0]              repeat_out;
    logic                      horn;
    logic                      bell;
    logic                      sf_lamp;
    logic                      bk_lamp;
    logic                      irq;
  } aas_state_t;

  aas_state_t q;
  aas_state_t d;

  function automatic logic [31:0] aas_zext(input logic [N-1:0] v);
    aas_zext = 32'(v);
  endfunction : aas_zext

  function automatic logic [31:0] aas_merge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    aas_merge = r;
  endfunction : aas_merge

  // One supply monitor: counts qualified ticks while failed, fires once the delay is reached.
  function automatic logic [DLY_W+1:0] aas_monitor(input logic             fail,
                                                   input logic             tick,
                                                   input logic [DLY_W-1:0] cnt,
                                                   input logic [DLY_W-1:0] dly);
    logic [DLY_W-1:0] c;
    c = cnt;
    if (!fail) begin
      c = '0;
    end else if (tick && (c < dly)) begin
      c = c + 1'b1;
    end
    aas_monitor = {fail, fail && (c >= dly), c};
  endfunction : aas_monitor

  logic [NP-1:0]    pins;
  logic [N_BTN-1:0] btn;
  logic [N_BTN-1:0] press;
  logic [N-1:0]     abn;
  logic [N-1:0]     qual_n;
  logic [N-1:0]     new_al;
  logic [N-1:0]     lit;
  logic             tick;
  logic             sf_fail;
  logic             bk_fail;
  logic [DLY_W+1:0] sf_m;
  logic [DLY_W+1:0] bk_m;
  logic [31:0]      rd;
  logic [31:0]      wv;
  logic             acc;
  logic [2:0]       ev;
  logic [2:0]       rclr;

  assign pins = {BACKUP_OK_I, SUPPLY_OK_I, SF_CANCEL_I, SUPPLY_TEST_I, HORN_TEST_I,
                 FLASH_TEST_I, LAMP_TEST_I, CLEAR_I, ACCEPT_I, FAULT_I};

  always_comb begin
    d = q;
    rd = '0;
    wv = '0;
    // Only the second stage is read; the first may be metastable.
    d.sync1 = pins;
    d.sync2 = q.sync1;
    btn = q.sync2[NP-1:N];
    d.btn_prev = btn;
    press = btn & ~q.btn_prev;

    tick = (q.pre == PW'(TICK_CYCLES - 1));
    d.pre = tick ? '0 : q.pre + 1'b1;

    abn = q.sync2[N-1:0] ^ q.polarity;
    for (int i = 0; i < N; i++) begin
      if (!abn[i]) begin
        d.deb[i] = '0;
      end else if (tick && (q.deb[i] != DEB_W'(DEB_TICKS))) begin
        d.deb[i] = q.deb[i] + 1'b1;
      end
      qual_n[i] = abn[i] && (d.deb[i] == DEB_W'(DEB_TICKS));
    end
    d.qual = qual_n;
    new_al = qual_n & ~q.qual;

    // A new alarm wins over a same-cycle accept so it is never lost.
    d.flash = (q.flash & ~{N{press[BTN_ACCEPT]}}) | new_al;
    d.steady = (q.steady | (q.flash & {N{press[BTN_ACCEPT]}})) & ~new_al;
    if (press[BTN_CLEAR]) begin
      d.steady = d.steady & qual_n;
    end

    if (tick) begin
      if (q.fcnt == FLASH_W'(FLASH_TICKS - 1)) begin
        d.fcnt = '0;
        d.phase = ~q.phase;
      end else begin
        d.fcnt = q.fcnt + 1'b1;
      end
    end

    sf_fail = ~btn[BTN_SUPPLY_OK] | btn[BTN_SUPPLY_TST];
    bk_fail = ~btn[BTN_BACKUP_OK] | btn[BTN_SUPPLY_TST];
    sf_m = aas_monitor(sf_fail, tick, q.sf_cnt, q.sf_delay);
    bk_m = aas_monitor(bk_fail, tick, q.bk_cnt, q.sf_delay);
    d.sf_cnt = sf_m[DLY_W-1:0];
    d.sf_act = sf_m[DLY_W];
    d.bk_cnt = bk_m[DLY_W-1:0];
    d.bk_act = bk_m[DLY_W];
    // Cancel only acts on a sounding alarm, so an early press cannot pre-silence the next one.
    d.sf_sil = sf_m[DLY_W] & (q.sf_sil | press[BTN_SF_CANCEL]);
    d.bk_sil = bk_m[DLY_W] & (q.bk_sil | press[BTN_SF_CANCEL]);

    for (int i = 0; i < N; i++) begin
      lit[i] = q.flash[i] ? q.phase : (q.steady[i] | q.qual[i] | btn[BTN_LAMP_TEST]);
    end
    if (btn[BTN_FLASH_TEST]) begin
      lit = lit | {N{q.phase}};
    end
    d.lamp_trip = lit & q.trip_class;
    d.lamp_warn = lit & ~q.trip_class;
    d.repeat_out = q.flash | q.steady;
    d.horn = (|q.flash) | btn[BTN_HORN_TEST];
    d.bell = (q.sf_act & ~q.sf_sil) | (q.bk_act & ~q.bk_sil);
    d.sf_lamp = q.sf_act | btn[BTN_LAMP_TEST];
    d.bk_lamp = q.bk_act | btn[BTN_LAMP_TEST];

    if (AVS_ADDRESS_I == REG_POLARITY) begin
      rd = aas_zext(q.polarity);
    end else if (AVS_ADDRESS_I == REG_CLASS) begin
      rd = aas_zext(q.trip_class);
    end else if (AVS_ADDRESS_I == REG_ALARM) begin
      rd = aas_zext(q.flash | q.steady);
    end else if (AVS_ADDRESS_I == REG_FLASHING) begin
      rd = aas_zext(q.flash);
    end else if (AVS_ADDRESS_I == REG_INPUT) begin
      rd = aas_zext(q.qual);
    end else if (AVS_ADDRESS_I == REG_SF_DELAY) begin
      rd = 32'(q.sf_delay);
    end else if (AVS_ADDRESS_I == REG_IRQ_STAT) begin
      rd = 32'(q.irq_stat);
    end else if (AVS_ADDRESS_I == REG_IRQ_MASK) begin
      rd = 32'(q.irq_mask);
    end else if (AVS_ADDRESS_I == REG_MONITOR) begin
      rd = 32'({q.bk_sil, q.bk_act, q.sf_sil, q.sf_act});
    end else begin
      rd = '0;
    end

    // Every access gets exactly one wait cycle, so read data always come from a flop.
    d.wait_req = ~(q.wait_req & (AVS_READ_I | AVS_WRITE_I));
    if (q.wait_req & AVS_READ_I) begin
      d.rdata = rd;
    end
    acc = ~q.wait_req;
    wv = aas_merge(rd, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
    if (acc && AVS_WRITE_I) begin
      if (AVS_ADDRESS_I == REG_POLARITY) begin
        d.polarity = wv[N-1:0];
      end else if (AVS_ADDRESS_I == REG_CLASS) begin
        d.trip_class = wv[N-1:0];
      end else if (AVS_ADDRESS_I == REG_SF_DELAY) begin
        d.sf_delay = wv[DLY_W-1:0];
      end else if (AVS_ADDRESS_I == REG_IRQ_MASK) begin
        d.irq_mask = wv[2:0];
      end
    end

    ev = {d.bk_act & ~q.bk_act, d.sf_act & ~q.sf_act, |new_al};
    // Only bits that went out in the read data are cleared; a wait-cycle event is kept.
    rclr = (acc && AVS_READ_I && (AVS_ADDRESS_I == REG_IRQ_STAT)) ? q.rdata[2:0] : 3'h0;
    // A new event in the clearing read cycle survives.
    d.irq_stat = (q.irq_stat & ~rclr) | ev;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.polarity <= POLARITY_RST[N-1:0];
      q.trip_class <= CLASS_RST[N-1:0];
      q.sf_delay <= SF_DELAY_RST;
      q.irq_mask <= IRQ_MASK_RST;
      q.wait_req <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign AVS_READDATA_O    = q.rdata;
  assign AVS_WAITREQUEST_O = q.wait_req;
  assign LAMP_TRIP_O       = q.lamp_trip;
  assign LAMP_WARN_O       = q.lamp_warn;
  assign REPEAT_O          = q.repeat_out;
  assign HORN_O            = q.horn;
  assign BELL_O            = q.bell;
  assign SF_LAMP_O         = q.sf_lamp;
  assign BK_LAMP_O         = q.bk_lamp;
  assign IRQ_O             = q.irq;

endmodule : aas_sequencer

// File: verilog/aas_pkg.sv
/*
  Constants, register map and timing figures shared by the alarm annunciator sequencer.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus with word addresses.
*/
package aas_pkg;

  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1000000) * TICK_US;
  localparam int unsigned N_POINTS       = 20;

  localparam int unsigned FLEETING_MS    = 15;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEB_TICKS      = (DEBOUNCE_MS * 1000) / TICK_US;
  localparam int unsigned FLASH_HALF_MS  = 500;
  localparam int unsigned FLASH_TICKS    = (FLASH_HALF_MS * 1000) / TICK_US;
  localparam int unsigned SF_DELAY_MS    = 2500;

  localparam int unsigned DEB_W          = 4;
  localparam int unsigned FLASH_W        = 9;
  localparam int unsigned DLY_W          = 12;
  localparam int unsigned ADDR_W         = 4;

  localparam logic [ADDR_W-1:0] REG_POLARITY = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CLASS    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ALARM    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_FLASHING = 4'h3;
  localparam logic [ADDR_W-1:0] REG_INPUT    = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SF_DELAY = 4'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h6;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h7;
  localparam logic [ADDR_W-1:0] REG_MONITOR  = 4'h8;

  localparam logic [31:0]      POLARITY_RST = 32'h0000_0000;
  localparam logic [31:0]      CLASS_RST    = 32'h0000_0000;
  localparam logic [DLY_W-1:0] SF_DELAY_RST = 12'h9c4;
  localparam logic [2:0]       IRQ_MASK_RST = 3'h0;

  localparam int unsigned IRQ_NEW_ALARM  = 0;
  localparam int unsigned IRQ_SUPPLY     = 1;
  localparam int unsigned IRQ_BACKUP     = 2;

  localparam int unsigned MON_SF_ACTIVE  = 0;
  localparam int unsigned MON_SF_SILENT  = 1;
  localparam int unsigned MON_BK_ACTIVE  = 2;
  localparam int unsigned MON_BK_SILENT  = 3;

  localparam int unsigned BTN_ACCEPT     = 0;
  localparam int unsigned BTN_CLEAR      = 1;
  localparam int unsigned BTN_LAMP_TEST  = 2;
  localparam int unsigned BTN_FLASH_TEST = 3;
  localparam int unsigned BTN_HORN_TEST  = 4;
  localparam int unsigned BTN_SUPPLY_TST = 5;
  localparam int unsigned BTN_SF_CANCEL  = 6;
  localparam int unsigned BTN_SUPPLY_OK  = 7;
  localparam int unsigned BTN_BACKUP_OK  = 8;
  localparam int unsigned N_BTN          = 9;

endpackage : aas_pkg

// File: testbench/aas_sequencer_props.sv
/*
  Port-level checker for the alarm annunciator sequencer.
  Assumes it is bound to aas_sequencer and sees only that module's ports.
*/
`timescale 1ns/100ps
module aas_seq_chk #(
  parameter int unsigned N = 20
) (
  input  wire logic         CLK_I,
  input  wire logic         RST_N_I,
  input  wire logic         ACCEPT_I,
  input  wire logic         CLEAR_I,
  input  wire logic         LAMP_TEST_I,
  input  wire logic         FLASH_TEST_I,
  input  wire logic         HORN_TEST_I,
  input  wire logic         SF_CANCEL_I,
  input  wire logic         SUPPLY_OK_I,
  input  wire logic         AVS_READ_I,
  input  wire logic         AVS_WRITE_I,
  input  wire logic         AVS_WAITREQUEST_O,
  input  wire logic [N-1:0] LAMP_TRIP_O,
  input  wire logic [N-1:0] LAMP_WARN_O,
  input  wire logic [N-1:0] REPEAT_O,
  input  wire logic         HORN_O,
  input  wire logic         BELL_O,
  input  wire logic         SF_LAMP_O,
  input  wire logic         BK_LAMP_O
);
  logic [3:0] ht_q;
  logic [3:0] tst_q;
  logic [3:0] clr_q;
  logic [3:0] ok_q;
  // Ages saturate, so a long quiet spell never wraps back into the recent window.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ht_q  <= 4'hf;
      tst_q <= 4'hf;
      clr_q <= 4'hf;
      ok_q  <= 4'hf;
    end else begin
      ht_q  <= HORN_TEST_I ? 4'h0 : ht_q + {3'h0, ht_q != 4'hf};
      tst_q <= (LAMP_TEST_I | FLASH_TEST_I) ? 4'h0 : tst_q + {3'h0, tst_q != 4'hf};
      clr_q <= CLEAR_I ? 4'h0 : clr_q + {3'h0, clr_q != 4'hf};
      ok_q  <= !SUPPLY_OK_I ? 4'h0 : ok_q + {3'h0, ok_q != 4'hf};
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  AST_CLASS_EXCL: assert property ((LAMP_TRIP_O & LAMP_WARN_O) == '0)
    else $error("window lit in both colours");
  AST_DARK_IDLE: assert property ((REPEAT_O == '0 && tst_q > 4'h8) |->
    (LAMP_TRIP_O | LAMP_WARN_O) == '0) else $error("window lit without alarm");
  AST_HORN_CAUSE: assert property (HORN_O |-> (REPEAT_O != '0 || ht_q < 4'h8))
    else $error("horn without alarm");
  AST_ACCEPT_QUIET: assert property (($rose(ACCEPT_I) && ht_q > 4'h8) |-> ##[1:8] !HORN_O)
    else $error("horn not silenced by accept");
  AST_REPEAT_HOLD: assert property ((($past(REPEAT_O) & ~REPEAT_O) != '0) |-> clr_q < 4'h8)
    else $error("alarm dropped without clear");
  AST_CANCEL_BELL: assert property ($rose(SF_CANCEL_I) |-> ##[1:8] !BELL_O)
    else $error("bell not cancelled");
  AST_SF_RETURN: assert property ($fell(SF_LAMP_O) |-> ok_q >= 4'h2)
    else $error("supply window dropped while supply absent");
  AST_BELL_LAMP: assert property (BELL_O |-> (SF_LAMP_O || BK_LAMP_O))
    else $error("bell without failure window");
  AST_WAIT_ONE: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("bus answer late");
  AST_WAIT_BACK: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("bus answer held too long");
  COV_HORN: cover property ($rose(HORN_O));
  COV_SF_QUIET: cover property (SF_LAMP_O && !BELL_O);
  COV_BK_BELL: cover property (BK_LAMP_O && BELL_O);
endmodule : aas_seq_chk

bind aas_sequencer aas_seq_chk #(.N(N)) u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .ACCEPT_I(ACCEPT_I), .CLEAR_I(CLEAR_I), .LAMP_TEST_I(LAMP_TEST_I),
  .FLASH_TEST_I(FLASH_TEST_I), .HORN_TEST_I(HORN_TEST_I), .SF_CANCEL_I(SF_CANCEL_I),
  .SUPPLY_OK_I(SUPPLY_OK_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LAMP_TRIP_O(LAMP_TRIP_O),
  .LAMP_WARN_O(LAMP_WARN_O), .REPEAT_O(REPEAT_O), .HORN_O(HORN_O), .BELL_O(BELL_O),
  .SF_LAMP_O(SF_LAMP_O), .BK_LAMP_O(BK_LAMP_O));

// File: testbench/aas_field_model.sv
/*
  Field contact model: turns the wanted contact state into a chattering contact.
  Assumes the bounce burst stays well inside the sequencer's debounce window.
*/
`timescale 1ns/100ps
module aas_field_model #(
  parameter int unsigned N = 20
) (
  input  wire logic         clk_i,
  input  wire logic [N-1:0] abn_i,
  output logic      [N-1:0] fault_o
);
  logic [N-1:0] old_q = '0;
  logic [2:0]   bnc_q = 3'h0;
  // Real contacts bounce, so each change flips back and forth for a few cycles first.
  always_ff @(posedge clk_i) begin
    old_q <= (bnc_q == 3'h0 && abn_i == old_q) ? abn_i : old_q;
    bnc_q <= (bnc_q != 3'h0) ? bnc_q - 3'h1 : ((abn_i != old_q) ? 3'h7 : 3'h0);
    if (bnc_q == 3'h1) begin
      old_q <= abn_i;
    end
  end
  assign fault_o = (bnc_q != 3'h0 && bnc_q[0]) ? old_q : abn_i;
endmodule : aas_field_model

// File: testbench/testbench.sv
/*
  Self-checking bench for the alarm annunciator sequencer.
  Assumes a 1 ms tick shortened to 20 clocks so every timed figure scales by that tick.
*/
`timescale 1ns/100ps
module testbench;
  import aas_pkg::*;
  logic                clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, chk = 1'b0;
  logic                sup_ok = 1'b1, bk_ok = 1'b1, wait_o, horn, bell, sfl, bkl, irq;
  logic [6:0]          btn = 7'h0;
  logic [N_POINTS-1:0] abn = '0, fault, trip, warn, rep;
  logic [ADDR_W-1:0]   addr = '0;
  logic [31:0]         wdat = '0, rdat, cls;
  logic [1:0]          sel = 2'h0;
  logic [31:0]         exp_q[$];
  int                  errors = 0, tests_run = 0, cyc = 0;
  always #25 clk = ~clk;
  aas_field_model #(.N(N_POINTS)) u_fld (.clk_i(clk), .abn_i(abn), .fault_o(fault));
  aas_sequencer #(.N(N_POINTS), .TICK_CYCLES(20)) uut (.CLK_I(clk), .RST_N_I(rst_n),
    .FAULT_I(fault), .ACCEPT_I(btn[BTN_ACCEPT]), .CLEAR_I(btn[BTN_CLEAR]),
    .LAMP_TEST_I(btn[BTN_LAMP_TEST]), .FLASH_TEST_I(btn[BTN_FLASH_TEST]),
    .HORN_TEST_I(btn[BTN_HORN_TEST]), .SUPPLY_TEST_I(btn[BTN_SUPPLY_TST]),
    .SF_CANCEL_I(btn[BTN_SF_CANCEL]), .SUPPLY_OK_I(sup_ok), .BACKUP_OK_I(bk_ok),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_o),
    .LAMP_TRIP_O(trip), .LAMP_WARN_O(warn), .REPEAT_O(rep), .HORN_O(horn), .BELL_O(bell),
    .SF_LAMP_O(sfl), .BK_LAMP_O(bkl), .IRQ_O(irq));
  task automatic compare(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : compare
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  function automatic logic [31:0] view(input logic [1:0] s);
    case (s)
      2'h0: view = {12'h0, rep};
      2'h1: view = {12'h0, trip};
      2'h2: view = {12'h0, warn};
      default: view = {27'h0, irq, bkl, sfl, bell, horn};
    endcase
  endfunction : view
  // The watcher takes the oldest note whenever a read answer or a port sample appears.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd && wait_o === 1'b0) compare(rdat, exp_q.pop_front());
    else if (chk) compare(view(sel), exp_q.pop_front());
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (wait_o !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rdx
  task automatic look(input logic [1:0] s, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    sel <= s;
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask : look
  task automatic press(input int b, input int len);
    btn[b] <= 1'b1;
    repeat (len) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : press
  initial begin
    void'($urandom(32'hf60a));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdx(REG_POLARITY, POLARITY_RST);
    rdx(REG_CLASS, CLASS_RST);
    rdx(REG_SF_DELAY, {20'h0, SF_DELAY_RST});
    rdx(REG_IRQ_MASK, {29'h0, IRQ_MASK_RST});
    bus(1'b1, REG_ALARM, 32'hffffffff);
    rdx(REG_ALARM, 32'h0);
    rdx(4'hf, 32'h0);
    $display("test registers done");
    cls = $urandom() & 32'hfffff;
    bus(1'b1, REG_CLASS, cls);
    abn <= '1;
    repeat (260) @(posedge clk);
    look(2'h0, 32'hfffff);
    look(2'h3, 32'h1);
    look(2'h1, 32'h0);
    rdx(REG_FLASHING, 32'hfffff);
    press(BTN_ACCEPT, 8);
    look(2'h1, cls);
    look(2'h2, ~cls & 32'hfffff);
    look(2'h3, 32'h0);
    press(BTN_CLEAR, 8);
    look(2'h0, 32'hfffff);
    abn <= '0;
    repeat (260) @(posedge clk);
    press(BTN_CLEAR, 8);
    look(2'h1, 32'h0);
    rdx(REG_IRQ_STAT, 32'h1);
    $display("test sequence done");
    abn[3] <= 1'b1;
    repeat (300) @(posedge clk);
    abn[3] <= 1'b0;
    abn[4] <= 1'b1;
    repeat (100) @(posedge clk);
    abn[4] <= 1'b0;
    repeat (300) @(posedge clk);
    look(2'h0, 32'h8);
    press(BTN_ACCEPT, 8);
    btn[BTN_LAMP_TEST] <= 1'b1;
    abn[5] <= 1'b1;
    repeat (260) @(posedge clk);
    look(2'h0, 32'h28);
    rdx(REG_FLASHING, 32'h20);
    press(BTN_ACCEPT, 8);
    look(2'h1, cls);
    btn[BTN_LAMP_TEST] <= 1'b0;
    repeat (12) @(posedge clk);
    look(2'h2, ~cls & 32'h28);
    btn[BTN_HORN_TEST] <= 1'b1;
    repeat (8) @(posedge clk);
    look(2'h3, 32'h1);
    btn[BTN_HORN_TEST] <= 1'b0;
    bus(1'b1, REG_POLARITY, 32'h80);
    repeat (260) @(posedge clk);
    look(2'h0, 32'ha8);
    press(BTN_ACCEPT, 8);
    $display("test fleeting done");
    bus(1'b1, REG_SF_DELAY, 32'h5);
    bus(1'b1, REG_IRQ_MASK, 32'h6);
    rdx(REG_IRQ_STAT, 32'h1);
    sup_ok <= 1'b0;
    repeat (50) @(posedge clk);
    sup_ok <= 1'b1;
    repeat (10) @(posedge clk);
    look(2'h3, 32'h0);
    sup_ok <= 1'b0;
    repeat (160) @(posedge clk);
    look(2'h3, 32'h16);
    press(BTN_SF_CANCEL, 8);
    look(2'h3, 32'h14);
    sup_ok <= 1'b1;
    repeat (10) @(posedge clk);
    look(2'h3, 32'h10);
    rdx(REG_IRQ_STAT, 32'h2);
    bk_ok <= 1'b0;
    repeat (160) @(posedge clk);
    look(2'h3, 32'h1a);
    bk_ok <= 1'b1;
    repeat (10) @(posedge clk);
    rdx(REG_IRQ_STAT, 32'h4);
    btn[BTN_SUPPLY_TST] <= 1'b1;
    repeat (160) @(posedge clk);
    look(2'h3, 32'h1e);
    btn[BTN_SUPPLY_TST] <= 1'b0;
    repeat (10) @(posedge clk);
    rdx(REG_IRQ_STAT, 32'h6);
    $display("test supply done");
    abn[0] <= 1'b1;
    btn[BTN_FLASH_TEST] <= 1'b1;
    // The blink phase first turns on after one half period, so wait well into that half.
    while (cyc < 15000) @(posedge clk);
    look(2'h1, cls);
    btn[BTN_FLASH_TEST] <= 1'b0;
    repeat (12) @(posedge clk);
    look(2'h1, cls & 32'ha9);
    look(2'h0, 32'ha9);
    look(2'h3, 32'h1);
    $display("test flasher done");
    final_report();
  end
endmodule : testbench
